// ### quad_dac_load_clear_control.sv
`timescale 1ns/10ps
`default_nettype none
module quad_dac_load_clear_control
    import dac_ctrl_pkg::*;
#(
    parameter int FIFO_DEPTH = FIFO_WORDS
) (
    // Clock and reset
    input  wire logic core_clk_in,
    input  wire logic rst_n_in,
    // Serial link pins
    input  wire logic sclk_in,
    input  wire logic frame_sync_n_in,
    input  wire logic serial_in_in,
    output logic      serial_out_out,
    // Update and clear pins
    input  wire logic load_strobe_n_in,
    input  wire logic async_clear_n_in,
    // Configuration
    input  wire logic clear_midscale_in,
    input  wire logic chain_enable_in,
    // Converter codes
    output dac_bank_t dac_code_out
);
    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [PIN_COUNT-1:0] sync1_q;  // First stage, read by sync2 only
    logic [PIN_COUNT-1:0] sync2_q;  // Stable copy
    logic [PIN_COUNT-1:0] prev_q;   // Delayed copy for edges
    wire  [PIN_COUNT-1:0] pin_raw = {chain_enable_in, clear_midscale_in,
                                     async_clear_n_in, load_strobe_n_in,
                                     serial_in_in, frame_sync_n_in,
                                     sclk_in};

    // Two stages plus edge history
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            sync1_q <= PIN_IDLE;
            sync2_q <= PIN_IDLE;
            prev_q  <= PIN_IDLE;
        end else begin
            sync1_q <= pin_raw;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    // Decoded levels and edges
    wire sclk_fall = prev_q[PIN_SCLK] & ~sync2_q[PIN_SCLK];
    wire sclk_rise = ~prev_q[PIN_SCLK] & sync2_q[PIN_SCLK];
    wire sync_low  = ~sync2_q[PIN_SYNC];
    wire sync_rise = ~prev_q[PIN_SYNC] & sync2_q[PIN_SYNC];
    wire load_low  = ~sync2_q[PIN_LOAD];
    wire load_fall = prev_q[PIN_LOAD] & ~sync2_q[PIN_LOAD];
    wire clear_on  = ~sync2_q[PIN_CLEAR];
    wire mid_sel   = sync2_q[PIN_MID];
    wire chain_on  = sync2_q[PIN_CHAIN];
    wire ser_bit   = sync2_q[PIN_DATA];

    // ****************************************
    // Input shift register
    // ****************************************
    localparam logic [CNT_W-1:0] FULL_BITS = CNT_W'(WORD_BITS);
    localparam logic [CNT_W-1:0] CNT_MAX   = '1;

    logic [WORD_BITS-1:0] shreg_q;     // Received bits, MSB first
    logic [CNT_W-1:0]     bit_cnt_q;   // Bits in this frame
    logic                 out_bit_q;   // Bit pushed out of the top
    logic                 serial_out_q;// Pin driver
    wire                  shift_en = sclk_fall & sync_low; // RQ7
    wire                  out_en   = sclk_rise & sync_low & chain_on;

    // Counter saturates so long frames never alias to a full one
    wire [CNT_W-1:0] bit_cnt_d = !sync_low ? '0 :
                     (shift_en && bit_cnt_q != CNT_MAX) ?
                     bit_cnt_q + 1'b1 : bit_cnt_q;
    // Output moves only after a rising serial clock, held low while chain is off
    wire serial_out_d = !chain_on ? 1'b0 :
                        out_en ? out_bit_q : serial_out_q; // RQ6

    // Shift on falling serial clock inside a frame
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            shreg_q   <= '0;
            out_bit_q <= 1'b0;
        end else if (shift_en) begin
            shreg_q   <= {shreg_q[WORD_BITS-2:0], ser_bit}; // RQ7
            out_bit_q <= shreg_q[WORD_BITS-1];           // RQ6
        end
    end

    // Counter and serial output
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            bit_cnt_q    <= '0;
            serial_out_q <= 1'b0;
        end else begin
            bit_cnt_q    <= bit_cnt_d;
            serial_out_q <= serial_out_d;
        end
    end
    assign serial_out_out = serial_out_q;

    // ****************************************
    // Frame buffer
    // ****************************************
    frame_word_t push_word;
    frame_word_t fifo_word;
    logic        fifo_in_ready;   // Low when buffer is full
    logic        fifo_out_valid;  // Word waiting
    logic [FRAME_W-1:0] fifo_raw;

    // Word taken only at select rise after exactly one full word
    wire push_valid = sync_rise & (bit_cnt_q == FULL_BITS); // RQ9
    assign push_word.direct = load_low;                     // RQ1
    assign push_word.chan   = shreg_q[CHAN_LSB +: CHAN_BITS];
    assign push_word.data   = shreg_q[DATA_BITS-1:0];
    assign fifo_word        = frame_word_t'(fifo_raw);
    // Drain stalls while clear holds, words wait in the buffer
    wire drain_ready = ~clear_on;
    wire drain_fire  = fifo_out_valid & drain_ready;

    frame_fifo #(
        .WIDTH (FRAME_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .core_clk_in   (core_clk_in),
        .rst_n_in      (rst_n_in),
        .in_valid_in   (push_valid),
        .in_ready_out  (fifo_in_ready),
        .in_data_in    (push_word),
        .out_valid_out (fifo_out_valid),
        .out_ready_in  (drain_ready),
        .out_data_out  (fifo_raw)
    );

    // ****************************************
    // Input and converter registers
    // ****************************************
    dac_bank_t input_q;       // Staged codes
    dac_bank_t input_d;
    dac_bank_t dac_q;         // Live codes
    dac_bank_t dac_d;
    logic      pending_q;     // Strobe fell, bank load owed

    // Bank load waits until earlier frames are applied
    wire apply_fire = pending_q & ~fifo_out_valid;             // RQ3
    // A new strobe edge wins over the completing load
    wire pending_d  = load_fall | (pending_q & ~apply_fire);
    wire [DATA_BITS-1:0] clear_code = mid_sel ? MID_CODE
                                              : ZERO_CODE;     // RQ10

    for (genvar ch = 0; ch < CHAN_COUNT; ch++) begin : g_chan
        wire hit = drain_fire & (fifo_word.chan == CHAN_BITS'(ch));
        // Every frame stages its code
        assign input_d[ch] = hit ? fifo_word.data : input_q[ch]; // RQ2
        // Clear first, then bank load, then direct update
        assign dac_d[ch] = clear_on ? clear_code :               // RQ5
                           apply_fire ? input_q[ch] :            // RQ3
                           (hit && fifo_word.direct) ?
                           fifo_word.data : dac_q[ch];           // RQ1
    end

    // Register banks; reset puts the power-on code out
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            input_q   <= {CHAN_COUNT{RESET_CODE}};
            dac_q     <= {CHAN_COUNT{RESET_CODE}};               // RQ8
            pending_q <= 1'b0;
        end else begin
            input_q   <= input_d;
            dac_q     <= dac_d;
            pending_q <= pending_d;
        end
    end
    assign dac_code_out = dac_q;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);

    a_reset_zero_codes: assert property (disable iff (1'b0) // RQ8
        !rst_n_in |=> dac_q == {CHAN_COUNT{RESET_CODE}})
        else $error("codes not zero after reset");
    a_clear_zero_scale: assert property ( // RQ5
        clear_on && !mid_sel |=> dac_q == {CHAN_COUNT{ZERO_CODE}})
        else $error("clear did not force zero scale");
    a_clear_mid_scale: assert property ( // RQ10
        clear_on && mid_sel |=> dac_q == {CHAN_COUNT{MID_CODE}})
        else $error("clear did not force midscale");
    a_direct_update: assert property ( // RQ1
        drain_fire && fifo_word.direct && !clear_on |=>
        dac_q[$past(fifo_word.chan)] == $past(fifo_word.data))
        else $error("direct write did not update channel");
    a_deferred_hold: assert property ( // RQ2
        drain_fire && !fifo_word.direct && !clear_on |=>
        dac_q == $past(dac_q) &&
        input_q[$past(fifo_word.chan)] == $past(fifo_word.data))
        else $error("deferred write changed output");
    a_bank_load_all: assert property ( // RQ3
        apply_fire && !clear_on |=> dac_q == $past(input_q))
        else $error("strobe load did not copy all channels");
    a_bank_load_soon: assert property ( // RQ3
        load_fall && !clear_on |-> ##[0:6] (apply_fire || clear_on))
        else $error("strobe load never happened");
    a_shift_in_bit: assert property ( // RQ7
        shift_en |=> shreg_q[0] == $past(ser_bit) && bit_cnt_q != '0)
        else $error("falling clock did not shift");
    a_full_word_only: assert property ( // RQ9
        sync_rise && bit_cnt_q != FULL_BITS |=>
        $stable(fifo_out_valid) || $fell(fifo_out_valid))
        else $error("short frame entered buffer");
    a_out_on_rise: assert property ( // RQ6
        out_en |=> serial_out_q == $past(out_bit_q))
        else $error("serial out missed rising clock");
    a_out_steady: assert property ( // RQ6
        (!sclk_rise && chain_on) ##1 chain_on |-> $stable(serial_out_q))
        else $error("serial out moved without rising clock");

    c_direct_write: cover property (drain_fire && fifo_word.direct);
    c_bank_load:    cover property (apply_fire && !clear_on);
    c_clear_mid:    cover property (clear_on && mid_sel);
    c_buffer_full:  cover property (push_valid && !fifo_in_ready);
endmodule : quad_dac_load_clear_control
`default_nettype wire

// ### dac_ctrl_pkg.sv
// Behaviour
// RQ1 - Strobe low: frame end updates addressed channel
// RQ2 - Strobe high: write input register only, defer
// RQ3 - Strobe falling edge loads all four channels
// RQ4 - Host keeps strobe driven, never floating
// RQ5 - Clear low forces zero or midscale code
// RQ6 - Serial out changes after rising serial clock
// RQ7 - Shift on falling clock, latch at select rise
// RQ8 - Reset loads all output codes with zero
// RQ9 - Only full-length frames are interpreted
// RQ10 - Clear level chosen by stable configuration input
`default_nettype none
package dac_ctrl_pkg;
    // ****************************************
    // Frame format
    // ****************************************
    localparam int WORD_BITS  = 24;   // Bits per frame
    localparam int DATA_BITS  = 16;   // Code width
    localparam int CHAN_BITS  = 2;    // Channel address width
    localparam int CHAN_LSB   = 16;   // Address position in word
    localparam int CHAN_COUNT = 4;    // Channels
    localparam int CNT_W      = 5;    // Bit counter width
    localparam int FIFO_WORDS = 4;    // Frame buffer depth

    // ****************************************
    // Codes
    // ****************************************
    localparam logic [15:0] ZERO_CODE  = 16'h0000; // Zero-scale
    localparam logic [15:0] MID_CODE   = 16'h8000; // Midscale
    localparam logic [15:0] RESET_CODE = 16'h0000; // Power-on code

    // ****************************************
    // Pin synchroniser positions
    // ****************************************
    localparam int PIN_COUNT = 7;
    localparam int PIN_SCLK  = 0;
    localparam int PIN_SYNC  = 1;
    localparam int PIN_DATA  = 2;
    localparam int PIN_LOAD  = 3;
    localparam int PIN_CLEAR = 4;
    localparam int PIN_MID   = 5;
    localparam int PIN_CHAIN = 6;
    localparam logic [6:0] PIN_IDLE = 7'h1a; // Select, strobe, clear high

    // ****************************************
    // Types
    // ****************************************
    typedef struct packed {
        logic                 direct; // Strobe was low at frame end
        logic [CHAN_BITS-1:0] chan;   // Addressed channel
        logic [DATA_BITS-1:0] data;   // Channel code
    } frame_word_t;

    localparam int FRAME_W = 1 + CHAN_BITS + DATA_BITS;

    typedef logic [CHAN_COUNT-1:0][DATA_BITS-1:0] dac_bank_t;
endpackage : dac_ctrl_pkg
`default_nettype wire

// ### frame_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module frame_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input  wire logic             core_clk_in,
    input  wire logic             rst_n_in,
    // Fill side
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    // Drain side
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic [WIDTH-1:0]      out_data_out
);
    // ****************************************
    // Storage and pointers
    // ****************************************
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PW:0]   FULL_CNT = (PW+1)'(DEPTH);
    localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_q [DEPTH];  // Word storage
    logic [PW-1:0]    wr_q;           // Write pointer
    logic [PW-1:0]    rd_q;           // Read pointer
    logic [PW:0]      cnt_q;          // Words held
    wire              push = in_valid_in & in_ready_out;
    wire              pop  = out_valid_out & out_ready_in;

    // Honest flags from the word count
    assign in_ready_out  = (cnt_q != FULL_CNT);
    assign out_valid_out = (cnt_q != '0);
    assign out_data_out  = mem_q[rd_q];

    // Storage write
    always_ff @(posedge core_clk_in) begin
        if (push) begin
            mem_q[wr_q] <= in_data_in;
        end
    end

    // Pointers and count
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == LAST_PTR) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == LAST_PTR) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule : frame_fifo
`default_nettype wire

// ### host_link_model.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Serial host: drives one frame per start
// ****************************************
module host_link_model (
    // Clock
    input  wire logic        core_clk_in,
    // Requests from the bench
    input  wire logic        start_in,
    input  wire logic [23:0] word_in,
    input  wire logic [4:0]  nbits_in,
    // Far side pins
    output logic             sclk_out,
    output logic             frame_sync_n_out,
    output logic             serial_in_out,
    input  wire logic        serial_out_in,
    // Status and captured echo
    output logic             busy_out,
    output logic [23:0]      echo_out
);
    // Idle levels, clock stands still low
    initial begin
        sclk_out = 1'b0;
        frame_sync_n_out = 1'b1;
        serial_in_out = 1'b0;
        busy_out = 1'b0;
        echo_out = 24'h000000;
    end

    // Frame: 4 core clocks each sclk phase (160 ns period)
    always @(posedge core_clk_in) begin
        if (start_in && !busy_out) begin
            busy_out <= 1'b1;
            frame_sync_n_out <= 1'b0;
            repeat (4) @(posedge core_clk_in);
            for (int i = 0; i < nbits_in; i++) begin
                sclk_out <= 1'b1;
                serial_in_out <= word_in[23-i];
                repeat (4) @(posedge core_clk_in);
                sclk_out <= 1'b0;
                repeat (2) @(posedge core_clk_in);
                echo_out <= {echo_out[22:0], serial_out_in};
                repeat (2) @(posedge core_clk_in);
            end
            frame_sync_n_out <= 1'b1;
            serial_in_out <= ~serial_in_out; // Last data bit inverted
            repeat (4) @(posedge core_clk_in);
            busy_out <= 1'b0;
        end
    end
endmodule : host_link_model
`default_nettype wire

// ### testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import dac_ctrl_pkg::*;
    // ****************************************
    // Signals
    // ****************************************
    logic        core_clk_in, rst_n_in, sclk, sync_n, sdi, serial_out;
    logic        load_strobe_n, clear_n, mid, chain, start, busy;
    logic [23:0] word, echo;
    logic [4:0]  nbits;
    dac_bank_t   code;
    int          n_fail, comparisons, cycles;

    // ****************************************
    // Design and host model
    // ****************************************
    quad_dac_load_clear_control DUT (
        .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .sclk_in(sclk),
        .frame_sync_n_in(sync_n), .serial_in_in(sdi),
        .serial_out_out(serial_out),
        .load_strobe_n_in(load_strobe_n), .async_clear_n_in(clear_n),
        .clear_midscale_in(mid), .chain_enable_in(chain),
        .dac_code_out(code));
    host_link_model host (
        .core_clk_in(core_clk_in), .start_in(start), .word_in(word),
        .nbits_in(nbits), .sclk_out(sclk), .frame_sync_n_out(sync_n),
        .serial_in_out(sdi), .serial_out_in(serial_out), .busy_out(busy),
        .echo_out(echo));

    // Clock and timeout
    initial begin
        core_clk_in = 1'b0;
        forever #10 core_clk_in = ~core_clk_in;
    end
    always @(posedge core_clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail++;
            end_of_test();
        end
    end

    // ****************************************
    // Helpers
    // ****************************************
    task automatic cmp_code(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: code %h expected %h",
                     $time, got, exp);
        end
    endtask : cmp_code
    task automatic cmp_bits(input logic [22:0] got, input logic [22:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: echo %h expected %h",
                     $time, got, exp);
        end
    endtask : cmp_bits
    // One frame, then settle time for the update
    task automatic send(input logic [1:0] ch, input logic [15:0] val,
                        input logic [5:0] top, input logic [4:0] n);
        int k;
        word <= {top, ch, val};
        nbits <= n;
        start <= 1'b1;
        @(posedge core_clk_in);
        start <= 1'b0;
        repeat (2) @(posedge core_clk_in);
        for (k = 0; k < 500 && busy === 1'b1; k++) @(posedge core_clk_in);
        repeat (8) @(posedge core_clk_in);
    endtask : send
    task automatic end_of_test();
        if (n_fail == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_of_test

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_direct();
        send(2'h2, 16'ha5c3, 6'h00, 5'd24);
        cmp_code(code[2], 16'ha5c3);
        cmp_code(code[0], RESET_CODE);
    endtask : t_direct
    task automatic t_deferred();
        load_strobe_n <= 1'b1;
        send(2'h0, 16'h1234, 6'h00, 5'd24);
        send(2'h1, 16'h5678, 6'h00, 5'd24);
        cmp_code(code[0], RESET_CODE);
        cmp_code(code[1], RESET_CODE);
        load_strobe_n <= 1'b0;
        repeat (10) @(posedge core_clk_in);
        cmp_code(code[0], 16'h1234);
        cmp_code(code[1], 16'h5678);
        cmp_code(code[2], 16'ha5c3);
    endtask : t_deferred
    task automatic t_short();
        send(2'h3, 16'hffff, 6'h00, 5'd23);
        cmp_code(code[3], RESET_CODE);
    endtask : t_short
    task automatic t_chain();
        chain <= 1'b1;
        send(2'h3, 16'h3c3c, 6'h2d, 5'd24);
        send(2'h3, 16'h0f0f, 6'h12, 5'd24);
        cmp_bits(echo[22:0], {6'h2d, 2'h3, 15'h1e1e});
        cmp_code(code[3], 16'h0f0f);
        chain <= 1'b0;
        send(2'h3, 16'h0f0f, 6'h3f, 5'd24);
        cmp_bits(echo[22:0], 23'h000000);
    endtask : t_chain
    task automatic t_clear(input logic m, input logic [15:0] exp);
        mid <= m;
        repeat (2) @(posedge core_clk_in);
        clear_n <= 1'b0;
        repeat (8) @(posedge core_clk_in);
        for (int c = 0; c < CHAN_COUNT; c++) cmp_code(code[c], exp);
        clear_n <= 1'b1;
        repeat (8) @(posedge core_clk_in);
    endtask : t_clear

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        {n_fail, comparisons, cycles} = '0;
        rst_n_in = 1'b0;
        {load_strobe_n, clear_n, mid, chain, start} = 5'b01000;
        word = 24'h000000;
        nbits = 5'd24;
        repeat (2) @(posedge core_clk_in);
        rst_n_in <= 1'b1;
        repeat (5) @(posedge core_clk_in);
        for (int c = 0; c < CHAN_COUNT; c++) begin
            cmp_code(code[c], RESET_CODE);
        end
        t_direct();
        t_deferred();
        t_short();
        t_chain();
        t_clear(1'b1, MID_CODE);
        t_clear(1'b0, ZERO_CODE);
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
